// file: rtl/tmr8_defs.svh
`ifndef TMR8_DEFS_SVH
`define TMR8_DEFS_SVH

// ----------------------------------------------------------
// register byte offsets on the apb slave
// ----------------------------------------------------------
`define TMR8_OFS_CTL1     8'h00
`define TMR8_OFS_CTL2     8'h04
`define TMR8_OFS_CNT      8'h08
`define TMR8_OFS_OCR      8'h0c
`define TMR8_OFS_ASR      8'h10
`define TMR8_OFS_FLG      8'h14

// ----------------------------------------------------------
// field positions
// ----------------------------------------------------------
`define TMR8_FOC_BIT      7
`define TMR8_EXT_CLOCK_INPUT_EN_BIT    6
`define TMR8_AS_BIT       5
`define TMR8_OVF_BIT      0
`define TMR8_CMP_BIT      1

// ----------------------------------------------------------
// reset values and counter limits
// ----------------------------------------------------------
`define TMR8_RST_BYTE     8'h00
`define TMR8_MAX          8'hff
`define TMR8_BOTTOM       8'h00

// ----------------------------------------------------------
// prescaler tap masks: divide by 8,32,64,128,256,1024
// ----------------------------------------------------------
`define TMR8_DIV1_MASK    10'h000
`define TMR8_DIV8_MASK    10'h007
`define TMR8_DIV32_MASK   10'h01f
`define TMR8_DIV64_MASK   10'h03f
`define TMR8_DIV128_MASK  10'h07f
`define TMR8_DIV256_MASK  10'h0ff
`define TMR8_DIV1024_MASK 10'h3ff

`endif

// file: rtl/tmr8_pkg.sv
package tmr8_pkg;
   // waveform modes, declaration order gives codes 0..3
   typedef enum logic [1:0] {
      WGM_NORMAL, WGM_PWM_PC, WGM_CTC, WGM_PWM_FAST
   } wgm_t;

   // first control register layout
   typedef struct packed {
      logic [1:0] com;    // compare output mode
      logic [3:0] rsvd;   // reads as zero
      wgm_t       wgm;    // waveform mode select
   } ctl1_t;

   // second control register layout
   typedef struct packed {
      logic       foc;    // force strobe, never read back
      logic [3:0] rsvd;   // reads as zero
      logic [2:0] cs;     // clock source select
   } ctl2_t;
endpackage

// file: rtl/tmr8_async_timer.sv
// The address map and the APB register port were decided locally.
`timescale 1ns/10ps
`include "tmr8_defs.svh"
// Operation
// - mode codes: normal, phase pwm, ctc, fast
// - compare buffered in pwm; overflow at max/bottom
// - force strobe ignored in pwm modes
// - force gives immediate match on pin
// - force raises no flag, no ctc clear
// - force bit always reads zero
// - clock select: stop, undivided, divided taps
// - reserved bits read zero
// - count write blocks next compare match
// - compare register checked every timer tick
// - external buffer versus crystal oscillator enable
// - async select picks timer clock source
// - switching async may corrupt timer registers
// - async select kept only with rc clock
// - async writes set busy until transferred
// - count reads live, control and compare read temporary
// - count writes may skip a match
// - non-pwm output: off, toggle, clear, set
// - flags cleared by vector or one
module tmr8_async_timer
   import tmr8_pkg::*;
(
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_sys_rst,
   // apb slave
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [7:0]  i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic      [31:0] o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   // timer clock sources and system clock status
   input  wire logic        i_xtal_clk,
   input  wire logic        i_ext_clk,
   input  wire logic        i_sysclk_rc,
   // interrupt vector acknowledges
   input  wire logic        i_ovf_ack,
   input  wire logic        i_cmp_ack,
   // flags, pin and oscillator controls
   output logic             o_ovf_flag,
   output logic             o_cmp_flag,
   output logic             o_cmp_pin,
   output logic             o_cmp_pin_oe,
   output logic             o_ext_clk_buf_en,
   output logic             o_xtal_osc_en
);

   // ----------------------------------------------------------
   // state
   // ----------------------------------------------------------
   ctl1_t       ctl1_tmp_q;  // software copy of control one
   ctl1_t       ctl1_q;      // live control one
   logic  [2:0] cs_tmp_q;    // software copy of clock select
   logic  [2:0] cs_q;        // live clock select
   logic        foc_pend_q;  // force waiting for transfer
   logic  [7:0] cnt_tmp_q;   // pending count write
   logic  [7:0] cnt_q;       // live count
   logic  [7:0] ocr_tmp_q;   // software copy of compare
   logic  [7:0] ocr_buf_q;   // transferred compare value
   logic  [7:0] ocr_q;       // compare value in use
   logic        ext_clock_input_en_q;     // external clock enable
   logic        as_q;        // async clock select
   logic  [3:0] busy_q;      // cnt, ocr, ctl1, ctl2
   logic        dir_dn_q;    // phase pwm counting down
   logic        blk_q;       // match blocked after count write
   logic  [9:0] psc_q;       // prescaler
   logic  [2:0] sync_q;      // source clock synchroniser
   logic  [1:0] flg_q;       // cmp, ovf

   // ----------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------
   logic pready_q;
   logic acc;
   logic wr;
   logic wr_ctl1, wr_ctl2, wr_cnt, wr_ocr, wr_asr, wr_flg;

   // no wait state; read data comes from a flop loaded at setup
   assign acc     = i_psel & i_penable & pready_q;
   assign wr      = acc & i_pwrite;
   assign wr_ctl1 = wr & (i_paddr == `TMR8_OFS_CTL1);
   assign wr_ctl2 = wr & (i_paddr == `TMR8_OFS_CTL2);
   assign wr_cnt  = wr & (i_paddr == `TMR8_OFS_CNT);
   assign wr_ocr  = wr & (i_paddr == `TMR8_OFS_OCR);
   assign wr_asr  = wr & (i_paddr == `TMR8_OFS_ASR);
   assign wr_flg  = wr & (i_paddr == `TMR8_OFS_FLG);

   // ----------------------------------------------------------
   // timer clock source and prescaler
   // ----------------------------------------------------------
   logic       src_lvl;
   logic       src_tick;
   logic       commit;
   logic [9:0] div_mask;
   logic       tmr_tick;

   // external pin or crystal, picked by enable bit
   assign src_lvl = ext_clock_input_en_q ? i_ext_clk : i_xtal_clk;

   // stage one feeds only stage two
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         sync_q <= 3'h0;
      end else begin
         sync_q <= {sync_q[1:0], src_lvl};
      end
   end

   // io clock ticks every cycle when not async
   assign src_tick = as_q ? (sync_q[1] & ~sync_q[2]) : 1'b1;
   // transfers from temporary storage happen on async edges
   assign commit   = as_q & src_tick;

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         psc_q <= 10'h000;
      end else if (src_tick) begin
         psc_q <= psc_q + 10'h001;
      end
   end

   // tap mask for each clock select code
   always_comb begin
      unique case (cs_q)
         3'h2:    div_mask = `TMR8_DIV8_MASK;
         3'h3:    div_mask = `TMR8_DIV32_MASK;
         3'h4:    div_mask = `TMR8_DIV64_MASK;
         3'h5:    div_mask = `TMR8_DIV128_MASK;
         3'h6:    div_mask = `TMR8_DIV256_MASK;
         3'h7:    div_mask = `TMR8_DIV1024_MASK;
         default: div_mask = `TMR8_DIV1_MASK;
      endcase
   end

   // code zero stops the timer
   assign tmr_tick = src_tick & (cs_q != 3'h0)
                   & ((psc_q & div_mask) == div_mask);

   // ----------------------------------------------------------
   // register loads: direct when sync, via busy when async
   // ----------------------------------------------------------
   logic ld_ctl1, ld_ctl2, ld_cnt, ld_ocr;
   logic foc_v;
   logic pwm;
   logic foc_ev;

   // a write in the commit cycle wins and stays busy
   assign ld_cnt  = as_q ? (commit & busy_q[3] & ~wr_cnt)  : wr_cnt;
   assign ld_ocr  = as_q ? (commit & busy_q[2] & ~wr_ocr)  : wr_ocr;
   assign ld_ctl1 = as_q ? (commit & busy_q[1] & ~wr_ctl1) : wr_ctl1;
   assign ld_ctl2 = as_q ? (commit & busy_q[0] & ~wr_ctl2) : wr_ctl2;
   assign foc_v   = as_q ? foc_pend_q : i_pwdata[`TMR8_FOC_BIT];
   assign pwm     = (ctl1_q.wgm == WGM_PWM_PC)
                  | (ctl1_q.wgm == WGM_PWM_FAST);
   // strobe only acts in normal and ctc modes
   assign foc_ev  = ld_ctl2 & foc_v & ~pwm;

   // software-visible copies, loaded on every write
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ctl1_tmp_q <= ctl1_t'(`TMR8_RST_BYTE);
         cs_tmp_q   <= 3'h0;
         cnt_tmp_q  <= `TMR8_RST_BYTE;
         ocr_tmp_q  <= `TMR8_RST_BYTE;
         foc_pend_q <= 1'b0;
      end else begin
         if (wr_ctl1) begin
            ctl1_tmp_q      <= ctl1_t'(i_pwdata[7:0]);
            ctl1_tmp_q.rsvd <= 4'h0;
         end
         if (wr_ctl2) begin
            cs_tmp_q   <= i_pwdata[2:0];
            foc_pend_q <= i_pwdata[`TMR8_FOC_BIT];
         end else if (ld_ctl2) begin
            foc_pend_q <= 1'b0;
         end
         if (wr_cnt) begin
            cnt_tmp_q <= i_pwdata[7:0];
         end
         if (wr_ocr) begin
            ocr_tmp_q <= i_pwdata[7:0];
         end
      end
   end

   // busy flags: write sets, transfer clears, set wins
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         busy_q <= 4'h0;
      end else begin
         busy_q[3] <= as_q & (wr_cnt  | (busy_q[3] & ~commit));
         busy_q[2] <= as_q & (wr_ocr  | (busy_q[2] & ~commit));
         busy_q[1] <= as_q & (wr_ctl1 | (busy_q[1] & ~commit));
         busy_q[0] <= as_q & (wr_ctl2 | (busy_q[0] & ~commit));
      end
   end

   // live control and compare buffer
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ctl1_q    <= ctl1_t'(`TMR8_RST_BYTE);
         cs_q      <= 3'h0;
         ocr_buf_q <= `TMR8_RST_BYTE;
      end else begin
         if (ld_ctl1) begin
            ctl1_q <= as_q ? ctl1_tmp_q : ctl1_t'(i_pwdata[7:0]);
         end
         if (ld_ctl2) begin
            cs_q <= as_q ? cs_tmp_q : i_pwdata[2:0];
         end
         if (ld_ocr) begin
            ocr_buf_q <= as_q ? ocr_tmp_q : i_pwdata[7:0];
         end
      end
   end

   // async status; select kept only with rc system clock
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ext_clock_input_en_q <= 1'b0;
         as_q    <= 1'b0;
      end else if (wr_asr) begin
         ext_clock_input_en_q <= i_pwdata[`TMR8_EXT_CLOCK_INPUT_EN_BIT];
         // timer state is kept across a switch; software treats it as lost
         as_q    <= i_pwdata[`TMR8_AS_BIT] & i_sysclk_rc;
      end
   end

   // ----------------------------------------------------------
   // counter unit
   // ----------------------------------------------------------
   logic at_max;
   logic at_bot;
   logic match;
   logic ovf_ev;

   assign at_max = (cnt_q == `TMR8_MAX);
   assign at_bot = (cnt_q == `TMR8_BOTTOM);
   // compared on every timer tick unless just written
   assign match  = tmr_tick & (cnt_q == ocr_q) & ~blk_q;
   // overflow at bottom in phase pwm, at max otherwise
   assign ovf_ev = tmr_tick & ((ctl1_q.wgm == WGM_PWM_PC)
                             ? at_bot : at_max);

   // count sequence per waveform mode
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         cnt_q    <= `TMR8_RST_BYTE;
         dir_dn_q <= 1'b0;
      end else if (ld_cnt) begin
         // a write may jump past the compare value
         cnt_q <= as_q ? cnt_tmp_q : i_pwdata[7:0];
      end else if (tmr_tick) begin
         unique case (ctl1_q.wgm)
            WGM_CTC: begin
               // top is compare register; no clear on force
               cnt_q <= (cnt_q == ocr_q) ? `TMR8_BOTTOM
                                         : cnt_q + 8'h01;
            end
            WGM_PWM_PC: begin
               // up to max then down to bottom
               if (!dir_dn_q && at_max) begin
                  dir_dn_q <= 1'b1;
                  cnt_q    <= cnt_q - 8'h01;
               end else if (dir_dn_q && at_bot) begin
                  dir_dn_q <= 1'b0;
                  cnt_q    <= cnt_q + 8'h01;
               end else begin
                  cnt_q <= dir_dn_q ? cnt_q - 8'h01
                                    : cnt_q + 8'h01;
               end
            end
            default: begin
               // normal and fast pwm wrap at max
               cnt_q <= cnt_q + 8'h01;
            end
         endcase
      end
   end

   // match block lasts until the next timer tick
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         blk_q <= 1'b0;
      end else if (ld_cnt) begin
         blk_q <= 1'b1;
      end else if (tmr_tick) begin
         blk_q <= 1'b0;
      end
   end

   // compare value in use: immediate, or at top in pwm
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ocr_q <= `TMR8_RST_BYTE;
      end else if (!pwm || (tmr_tick && at_max)) begin
         ocr_q <= ocr_buf_q;
      end
   end

   // ----------------------------------------------------------
   // flags: set wins over clear
   // ----------------------------------------------------------
   logic [1:0] flg_set;
   logic [1:0] flg_clr;

   // forced compare never sets the compare flag
   assign flg_set = {match, ovf_ev};
   assign flg_clr = {i_cmp_ack | (wr_flg & i_pwdata[`TMR8_CMP_BIT]),
                     i_ovf_ack | (wr_flg & i_pwdata[`TMR8_OVF_BIT])};

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         flg_q <= 2'h0;
      end else begin
         flg_q <= (flg_q & ~flg_clr) | flg_set;
      end
   end

   // ----------------------------------------------------------
   // waveform output
   // ----------------------------------------------------------
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_cmp_pin <= 1'b0;
      end else if (!pwm) begin
         // force uses the mode bits present now
         if (match || foc_ev) begin
            unique case (ctl1_q.com)
               2'h1:    o_cmp_pin <= ~o_cmp_pin;
               2'h2:    o_cmp_pin <= 1'b0;
               2'h3:    o_cmp_pin <= 1'b1;
               default: o_cmp_pin <= o_cmp_pin;
            endcase
         end
      end else if (ctl1_q.com[1]) begin
         if (ctl1_q.wgm == WGM_PWM_FAST) begin
            // set or clear at bottom, opposite on match
            if (match) begin
               o_cmp_pin <= ctl1_q.com[0];
            end else if (tmr_tick && at_max) begin
               o_cmp_pin <= ~ctl1_q.com[0];
            end
         end else if (match) begin
            // phase pwm: direction picks the level
            o_cmp_pin <= dir_dn_q ? ~ctl1_q.com[0]
                                  : ctl1_q.com[0];
         end
      end
   end

   // pin enable; code one is disconnected in pwm
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_cmp_pin_oe <= 1'b0;
      end else begin
         o_cmp_pin_oe <= ctl1_q.com[1] | (ctl1_q.com[0] & ~pwm);
      end
   end

   // buffer and crystal never run together
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_ext_clk_buf_en <= 1'b0;
         o_xtal_osc_en    <= 1'b0;
      end else begin
         o_ext_clk_buf_en <= ext_clock_input_en_q & as_q;
         o_xtal_osc_en    <= ~ext_clock_input_en_q & as_q;
      end
   end

   assign o_ovf_flag = flg_q[`TMR8_OVF_BIT];
   assign o_cmp_flag = flg_q[`TMR8_CMP_BIT];

   // ----------------------------------------------------------
   // apb response: data latched at setup
   // ----------------------------------------------------------
   logic [7:0] rd_byte;
   logic       rd_ok;

   // count reads live; control and compare read temporary copies
   always_comb begin
      rd_ok   = 1'b1;
      rd_byte = 8'h00;
      unique case (i_paddr)
         `TMR8_OFS_CTL1: rd_byte = ctl1_tmp_q;
         `TMR8_OFS_CTL2: rd_byte = {5'h00, cs_tmp_q};
         `TMR8_OFS_CNT:  rd_byte = cnt_q;
         `TMR8_OFS_OCR:  rd_byte = ocr_tmp_q;
         `TMR8_OFS_ASR:  rd_byte = {1'b0, ext_clock_input_en_q, as_q, busy_q[3:2],
                                    1'b0, busy_q[1:0]};
         `TMR8_OFS_FLG:  rd_byte = {6'h00, flg_q};
         default:        rd_ok   = 1'b0;
      endcase
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         pready_q  <= 1'b0;
         o_prdata  <= 32'h0;
         o_pslverr <= 1'b0;
      end else begin
         pready_q <= i_psel & ~i_penable;
         if (i_psel && !i_penable) begin
            o_prdata  <= {24'h0, rd_byte};
            o_pslverr <= ~rd_ok;
         end
      end
   end
   assign o_pready = pready_q;

   // ----------------------------------------------------------
   // assertions
   // ----------------------------------------------------------
   property p_foc_rd_zero;
      @(posedge i_clk) disable iff (i_sys_rst)
      (acc && !i_pwrite && i_paddr == `TMR8_OFS_CTL2)
         |-> (o_prdata[7:3] == 5'h00);
   endproperty
   a_foc_rd_zero: assert property (p_foc_rd_zero)
      else $error("force bit read as one");

   property p_asr_rsvd;
      @(posedge i_clk) disable iff (i_sys_rst)
      (acc && !i_pwrite && i_paddr == `TMR8_OFS_ASR)
         |-> (o_prdata[7] == 1'b0 && o_prdata[2] == 1'b0);
   endproperty
   a_asr_rsvd: assert property (p_asr_rsvd)
      else $error("reserved status bit not zero");

   property p_as_forced;
      @(posedge i_clk) disable iff (i_sys_rst)
      (wr_asr && !i_sysclk_rc) |=> !as_q;
   endproperty
   a_as_forced: assert property (p_as_forced)
      else $error("async select kept without rc clock");

   property p_busy_set;
      @(posedge i_clk) disable iff (i_sys_rst)
      (as_q && wr_cnt && !wr_asr) |=> busy_q[3] ##0 !ld_cnt;
   endproperty
   a_busy_set: assert property (p_busy_set)
      else $error("count busy not set by async write");

   property p_blk_match;
      @(posedge i_clk) disable iff (i_sys_rst)
      ld_cnt ##1 (!ld_cnt && tmr_tick) |-> !match;
   endproperty
   a_blk_match: assert property (p_blk_match)
      else $error("match after count write");

   property p_ovf_max;
      @(posedge i_clk) disable iff (i_sys_rst)
      (tmr_tick && at_max && ctl1_q.wgm == WGM_NORMAL && !ld_cnt)
         |=> o_ovf_flag ##0 (cnt_q == `TMR8_BOTTOM);
   endproperty
   a_ovf_max: assert property (p_ovf_max)
      else $error("overflow missing at max");

   property p_stop;
      @(posedge i_clk) disable iff (i_sys_rst)
      (cs_q == 3'h0 && !ld_cnt) |=> $stable(cnt_q);
   endproperty
   a_stop: assert property (p_stop)
      else $error("count moved while stopped");

   property p_buf_en;
      @(posedge i_clk) disable iff (i_sys_rst)
      ##1 (o_ext_clk_buf_en == $past(ext_clock_input_en_q & as_q))
          && !(o_ext_clk_buf_en && o_xtal_osc_en);
   endproperty
   a_buf_en: assert property (p_buf_en)
      else $error("clock buffer enable wrong");

   property p_pwm_foc;
      @(posedge i_clk) disable iff (i_sys_rst)
      (ld_ctl2 && foc_v && pwm && !match && !tmr_tick)
         |=> $stable(o_cmp_pin);
   endproperty
   a_pwm_foc: assert property (p_pwm_foc)
      else $error("force acted in pwm mode");

endmodule

// file: bench/tmr8_async_timer_tb.sv
`timescale 1ns/10ps
`include "tmr8_defs.svh"
module tmr8_async_timer_tb;
   import tmr8_pkg::*;
   // ----------------------------------------------------------
   // stimulus and observed signals
   // ----------------------------------------------------------
   logic        i_clk = 1'b0, i_sys_rst = 1'b1;     // clock, reset
   logic        i_psel = 1'b0, i_penable = 1'b0;    // apb controls
   logic        i_pwrite = 1'b0;                    // apb direction
   logic [7:0]  i_paddr = 8'h00;                    // apb address
   logic [31:0] i_pwdata = 32'h0, o_prdata;         // apb data
   logic        o_pready, o_pslverr;                // apb answer
   logic        i_xtal_clk = 1'b0, i_ext_clk = 1'b0; // slow sources
   logic        i_sysclk_rc = 1'b0;                 // rc system clock
   logic        i_ovf_ack = 1'b0, i_cmp_ack = 1'b0; // vector acks
   logic        o_ovf_flag, o_cmp_flag, o_cmp_pin, o_cmp_pin_oe;
   logic        o_ext_clk_buf_en, o_xtal_osc_en;
   logic [5:0]  div_q = 6'h00;                      // slow divider
   int          errors = 0, total_checks = 0;       // counters
   logic [31:0] rd;                                 // last read word
   logic        er;                                 // last pslverr

   tmr8_async_timer dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
      .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
      .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
      .o_pready(o_pready), .o_pslverr(o_pslverr),
      .i_xtal_clk(i_xtal_clk), .i_ext_clk(i_ext_clk),
      .i_sysclk_rc(i_sysclk_rc), .i_ovf_ack(i_ovf_ack),
      .i_cmp_ack(i_cmp_ack), .o_ovf_flag(o_ovf_flag),
      .o_cmp_flag(o_cmp_flag), .o_cmp_pin(o_cmp_pin),
      .o_cmp_pin_oe(o_cmp_pin_oe), .o_ext_clk_buf_en(o_ext_clk_buf_en),
      .o_xtal_osc_en(o_xtal_osc_en));

   // ----------------------------------------------------------
   // clocks
   // ----------------------------------------------------------
   // 40 mhz core clock
   always #12.5 i_clk = ~i_clk;
   // slow crystal and external clock, 64 core cycles a period
   always @(posedge i_clk) begin
      div_q      <= div_q + 6'h01;
      i_xtal_clk <= div_q[5];
      i_ext_clk  <= div_q[5];
   end

   // ----------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------
   // verdict and end of run
   task automatic end_of_test();
      $display("checks %0d, mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // one compare for every result
   task automatic chk(input string nm, input logic [31:0] e, g);
      total_checks++;
      if (g !== e) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one apb transfer, held until pready seen at a rising edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge i_clk);
      i_psel <= 1'b1; i_pwrite <= w; i_paddr <= a; i_pwdata <= d;
      @(posedge i_clk);
      i_penable <= 1'b1;
      n = 0;
      // pready is judged at the rising edge itself, before it updates
      do begin
         @(posedge i_clk);
         n++;
         if (n > 20) begin errors++; end_of_test(); end
      end while (o_pready !== 1'b1);
      rd = o_prdata; er = o_pslverr;
      i_psel <= 1'b0; i_penable <= 1'b0;
   endtask
   // wait up to n cycles for a flag: c=0 overflow, c=1 compare
   task automatic wait_hi(input logic c, input int n);
      int k;
      for (k = 0; k < n && (c ? o_cmp_flag : o_ovf_flag) !== 1'b1; k++)
         @(negedge i_clk);
      if ((c ? o_cmp_flag : o_ovf_flag) !== 1'b1) begin
         errors++;
         end_of_test();
      end
   endtask

   // ----------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------
   // reset values, reserved bits, write-only force bit, unmapped
   task automatic t_regs();
      apb(0, `TMR8_OFS_ASR, 0); chk("asr rst", 32'h0, rd);
      apb(0, `TMR8_OFS_CNT, 0); chk("cnt rst", 32'h0, rd);
      apb(1, `TMR8_OFS_CTL1, 32'hff); apb(0, `TMR8_OFS_CTL1, 0);
      chk("ctl1 rsvd", 32'hc3, rd);
      apb(1, `TMR8_OFS_CTL1, 32'h00);
      apb(1, `TMR8_OFS_CTL2, 32'hf8); apb(0, `TMR8_OFS_CTL2, 0);
      chk("ctl2 rsvd foc", 32'h0, rd);
      apb(0, 8'h40, 0); chk("unmapped err", 32'h1, {31'h0, er});
   endtask
   // forced match in ctc: set, clear, toggle; no flag, no clear
   task automatic t_force();
      logic [1:0] cm [3] = '{2'b11, 2'b10, 2'b01};
      logic       ex [3] = '{1'b1, 1'b0, 1'b1};
      apb(1, `TMR8_OFS_OCR, 32'h40); apb(1, `TMR8_OFS_CNT, 32'h40);
      for (int i = 0; i < 3; i++) begin
         apb(1, `TMR8_OFS_CTL1, {24'h0, cm[i], 6'h02});
         apb(1, `TMR8_OFS_CTL2, 32'h80);
         repeat (2) @(posedge i_clk);
         chk("force pin", {31'h0, ex[i]}, {31'h0, o_cmp_pin});
         chk("pin oe", 32'h1, {31'h0, o_cmp_pin_oe});
      end
      apb(0, `TMR8_OFS_CNT, 0); chk("ctc no clear", 32'h40, rd);
      chk("force no flag", 32'h0, {31'h0, o_cmp_flag});
      apb(1, `TMR8_OFS_CTL1, 32'h83);
      apb(1, `TMR8_OFS_CTL2, 32'h80);
      repeat (2) @(posedge i_clk);
      chk("pwm force", 32'h1, {31'h0, o_cmp_pin});
      apb(1, `TMR8_OFS_CTL2, 32'h00);
      apb(1, `TMR8_OFS_CTL1, 32'h00);
      repeat (2) @(posedge i_clk);
      chk("pin off", 32'h0, {31'h0, o_cmp_pin_oe});
   endtask
   // overflow at max, vector ack clear
   task automatic t_ovf();
      apb(1, `TMR8_OFS_CNT, 32'hfd); apb(1, `TMR8_OFS_CTL2, 32'h01);
      wait_hi(1'b0, 20);
      apb(1, `TMR8_OFS_CTL2, 32'h00);
      @(posedge i_clk) i_ovf_ack <= 1'b1;
      @(posedge i_clk) i_ovf_ack <= 1'b0;
      repeat (2) @(posedge i_clk);
      chk("ovf ack", 32'h0, {31'h0, o_ovf_flag});
   endtask
   // compare match, one-to-clear, count write blocking next match
   task automatic t_cmp();
      apb(1, `TMR8_OFS_OCR, 32'h30); apb(1, `TMR8_OFS_CNT, 32'h2c);
      apb(1, `TMR8_OFS_CTL2, 32'h01);
      wait_hi(1'b1, 20);
      apb(1, `TMR8_OFS_FLG, 32'h02); apb(0, `TMR8_OFS_FLG, 0);
      chk("cmp w1c", 32'h0, rd);
      apb(1, `TMR8_OFS_CNT, 32'h30);
      repeat (6) @(posedge i_clk);
      chk("cnt write block", 32'h0, {31'h0, o_cmp_flag});
      apb(1, `TMR8_OFS_CTL2, 32'h00);
   endtask
   // ctc top follows compare register
   task automatic t_ctc();
      apb(1, `TMR8_OFS_OCR, 32'h05); apb(1, `TMR8_OFS_CTL1, 32'h02);
      apb(1, `TMR8_OFS_CNT, 32'h00); apb(1, `TMR8_OFS_CTL2, 32'h01);
      for (int i = 0; i < 5; i++) begin
         apb(0, `TMR8_OFS_CNT, 0);
         chk("ctc top", 32'h1, {31'h0, rd <= 32'h05});
      end
      apb(1, `TMR8_OFS_CTL2, 32'h00); apb(1, `TMR8_OFS_CTL1, 32'h00);
   endtask
   // async select refusal, external buffer, busy flag and transfer
   task automatic t_async();
      int k;
      apb(1, `TMR8_OFS_ASR, 32'h20); apb(0, `TMR8_OFS_ASR, 0);
      chk("as forced 0", 32'h0, rd);
      i_sysclk_rc <= 1'b1;
      apb(1, `TMR8_OFS_ASR, 32'h40); apb(1, `TMR8_OFS_ASR, 32'h60);
      repeat (2) @(posedge i_clk);
      chk("ext buf", 32'h1, {31'h0, o_ext_clk_buf_en});
      chk("xtal off", 32'h0, {31'h0, o_xtal_osc_en});
      for (k = 0; k < 70 && div_q != 6'h21; k++) @(negedge i_clk);
      apb(1, `TMR8_OFS_OCR, 32'h5a); apb(0, `TMR8_OFS_ASR, 0);
      chk("ocr busy", 32'h68, rd);
      apb(0, `TMR8_OFS_OCR, 0); chk("ocr temp", 32'h5a, rd);
      // poll until every busy bit reads clear before the count write
      for (k = 0; k < 30 && rd !== 32'h60; k++) apb(0, `TMR8_OFS_ASR, 0);
      chk("busy clear", 32'h60, rd);
      apb(1, `TMR8_OFS_CNT, 32'h10); apb(0, `TMR8_OFS_ASR, 0);
      chk("cnt busy", 32'h70, rd);
   endtask

   // ----------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------
   initial begin
      repeat (6) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      t_regs();
      t_force();
      t_ovf();
      t_cmp();
      t_ctc();
      t_async();
      end_of_test();
   end
endmodule
